// [hdl/e1mc_pkg.sv]
// ****************************************************************
// Constants for the E1 maintenance control registers
// ****************************************************************
package e1mc_pkg;

  // Register addresses on the host port
  localparam logic [4:0] ADDR_ERR_DBNC = 5'h10;
  localparam logic [4:0] ADDR_ACCESS = 5'h13;
  localparam logic [4:0] ADDR_JITTER = 5'h18;

  // Reset value shared by every field
  localparam logic [7:0] REG_RESET = 8'h00;

  // Error insertion and debounce register fields
  localparam int ERR_BPV_BIT = 7;
  localparam int ERR_CRC_BIT = 6;
  localparam int ERR_FAS_BIT = 5;
  localparam int ERR_NFAS_BIT = 4;
  localparam int ERR_FLOS_BIT = 3;
  localparam int ERR_PAY_BIT = 2;
  localparam int ERR_DBNC_BIT = 0;
  localparam logic [7:0] ERR_MASK = 8'hFD;

  // Access control register fields
  localparam int ACC_LOSSEL_BIT = 2;
  localparam int ACC_SEQ_BIT = 1;
  localparam int ACC_FP_BIT = 0;
  localparam logic [7:0] ACC_MASK = 8'h07;

  // Jitter attenuator control register fields
  localparam int JA_EN_BIT = 7;
  localparam int JA_DIR_BIT = 6;
  localparam int JA_CTR_BIT = 5;
  localparam int JA_DEPTH_LSB = 2;
  localparam int JA_DEPTH_W = 3;
  localparam int JA_CLR_BIT = 1;
  localparam logic [7:0] JA_MASK = 8'hFE;

  // FIFO depth grows in steps of 16 words, i.e. a shift of 4
  localparam int DEPTH_STEP_SHIFT = 4;

  // Signalling debounce timing
  localparam int CLK_KHZ = 125000;
  localparam int DEBOUNCE_MS = 14;
  localparam int DEBOUNCE_SLACK_MS = 2;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;
  localparam int DEBOUNCE_CNT_W = 21;

  // Signalling bits per time slot
  localparam int SIG_W = 4;

  // Host port sequencer states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_READ = 3'b010,
    BUS_WRITE = 3'b100
  } e1mc_bus_state_type;

endpackage

// [hdl/e1mc_sig_if.sv]
`timescale 1ns/1ps
// ****************************************************************
// Link between the register bank and the signalling debouncer
// ****************************************************************
interface e1mc_sig_if #(
  parameter int W = 4
) ();
  logic enable;
  logic [W-1:0] raw;
  logic [W-1:0] filtered;

  // Register bank side
  modport ctrl (output enable, output raw, input filtered);
  // Debouncer side
  modport filt (input enable, input raw, output filtered);
endinterface

// [hdl/e1mc_sig_debounce.sv]
`timescale 1ns/1ps
// ****************************************************************
// Received signalling debouncer
// ****************************************************************
module e1mc_sig_debounce #(
  parameter int W = 4,
  parameter int CNT_W = 21,
  parameter logic [CNT_W-1:0] LIMIT = 21'd1750000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Signalling link
  e1mc_sig_if.filt sig
);

  logic [W-1:0] cand;
  logic [W-1:0] next_cand;
  logic [W-1:0] filt_q;
  logic [W-1:0] next_filt_q;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  // A change must stay put for the whole period before it passes
  always_comb begin
    next_cand = cand;
    next_filt_q = filt_q;
    next_cnt = cnt;
    if (!sig.enable) begin
      next_cand = sig.raw;
      next_filt_q = sig.raw;
      next_cnt = '0;
    end else if (sig.raw != cand) begin
      next_cand = sig.raw;
      next_cnt = '0;
    end else if (cand != filt_q) begin
      if (cnt >= LIMIT - 1'b1) begin
        next_filt_q = cand;
        next_cnt = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end else begin
      next_cnt = '0;
    end
  end

  // State registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cand <= '0;
      filt_q <= '0;
      cnt <= '0;
    end else if (clk_en) begin
      cand <= next_cand;
      filt_q <= next_filt_q;
      cnt <= next_cnt;
    end
  end

  assign sig.filtered = filt_q;

endmodule

// [hdl/e1mc_maint_ctrl.sv]
`timescale 1ns/1ps
module e1mc_maint_ctrl #(
  parameter int SIG_W = e1mc_pkg::SIG_W,
  parameter int DEBOUNCE_CYCLES = e1mc_pkg::DEBOUNCE_CYCLES
) (
  // Clock, reset and clock enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Host microprocessor port
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  // Framer status inputs
  input wire logic line_loss_state,
  input wire logic frame_align_lost,
  input wire logic [SIG_W-1:0] sig_raw,
  // Transmit error insertion
  output logic bipolar_violation_insert,
  output logic crc_error_insert,
  output logic frame_align_error_insert,
  output logic nonframe_align_error_insert,
  output logic payload_error_insert,
  output logic forced_loss_of_signal,
  // Signalling and access control
  output logic signalling_debounce_select,
  output logic [SIG_W-1:0] sig_debounced,
  output logic loss_indicator_output,
  output logic test_sequence_select,
  output logic prbs_reset,
  output logic frame_pulse_format_select,
  // Jitter attenuator control
  output logic jitter_atten_tx_active,
  output logic jitter_atten_rx_active,
  output logic jitter_fifo_centre,
  output logic [7:0] jitter_fifo_depth,
  output logic jitter_atten_clear
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  localparam int PIN_W = 16;
  // Count limit cut on purpose to the debouncer counter width
  localparam int DBNC_W = e1mc_pkg::DEBOUNCE_CNT_W;
  localparam logic [DBNC_W-1:0] DBNC_LIMIT = DBNC_W'(DEBOUNCE_CYCLES);

  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] next_pin_q;
  logic [PIN_W-1:0] pin_raw;

  assign pin_raw = {~host_cs_n, ~host_rd_n, ~host_wr_n, host_addr, host_data_in};

  // A pin change counts once stages two and three agree
  always_comb begin
    next_pin_q = pin_q;
    for (int i = 0; i < PIN_W; i++) begin
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_q[i] = pin_s3[i];
      end
    end
  end

  // Three stage shift and the settled copy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_q <= '0;
    end else if (clk_en) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q <= next_pin_q;
    end
  end

  logic cs_act;
  logic rd_act;
  logic wr_act;
  logic [4:0] addr_q;
  logic [7:0] wdata_q;

  assign cs_act = pin_q[15];
  assign rd_act = pin_q[14];
  assign wr_act = pin_q[13];
  assign addr_q = pin_q[12:8];
  assign wdata_q = pin_q[7:0];

  // ****************************************************************
  // Host port sequencer and register bank
  // ****************************************************************

  e1mc_pkg::e1mc_bus_state_type bus_state;
  e1mc_pkg::e1mc_bus_state_type next_bus_state;
  logic [7:0] reg_err;
  logic [7:0] next_reg_err;
  logic [7:0] reg_acc;
  logic [7:0] next_reg_acc;
  logic [7:0] reg_ja;
  logic [7:0] next_reg_ja;
  logic [7:0] next_data_out;
  logic next_data_oe;
  logic [7:0] err_rise;
  logic next_prbs_reset;
  logic next_centre;
  logic [7:0] rd_mux;

  // Read multiplexer, unmapped addresses and unused bits read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr_q)
      e1mc_pkg::ADDR_ERR_DBNC: rd_mux = reg_err;
      e1mc_pkg::ADDR_ACCESS: rd_mux = reg_acc;
      e1mc_pkg::ADDR_JITTER: rd_mux = reg_ja;
      default: rd_mux = 8'h00;
    endcase
  end

  // One register update per strobe, insert bits flagged on 0 to 1
  always_comb begin
    next_bus_state = bus_state;
    next_reg_err = reg_err;
    next_reg_acc = reg_acc;
    next_reg_ja = reg_ja;
    next_data_out = host_data_out;
    next_data_oe = host_data_oe;
    err_rise = 8'h00;
    next_prbs_reset = 1'b0;
    next_centre = 1'b0;
    unique case (bus_state)
      e1mc_pkg::BUS_IDLE: begin
        if (cs_act && wr_act) begin
          next_bus_state = e1mc_pkg::BUS_WRITE;
          unique case (addr_q)
            e1mc_pkg::ADDR_ERR_DBNC: begin
              next_reg_err = wdata_q & e1mc_pkg::ERR_MASK;
              err_rise = next_reg_err & ~reg_err;
            end
            e1mc_pkg::ADDR_ACCESS: begin
              next_reg_acc = wdata_q & e1mc_pkg::ACC_MASK;
              next_prbs_reset = wdata_q[e1mc_pkg::ACC_SEQ_BIT];
            end
            e1mc_pkg::ADDR_JITTER: begin
              next_reg_ja = wdata_q & e1mc_pkg::JA_MASK;
              next_centre = wdata_q[e1mc_pkg::JA_CTR_BIT] ^
                            reg_ja[e1mc_pkg::JA_CTR_BIT];
            end
            default: begin
              next_reg_err = reg_err;
            end
          endcase
        end else if (cs_act && rd_act) begin
          next_bus_state = e1mc_pkg::BUS_READ;
          next_data_out = rd_mux;
          next_data_oe = 1'b1;
        end
      end
      e1mc_pkg::BUS_READ: begin
        next_data_out = rd_mux;
        if (!(cs_act && rd_act)) begin
          next_bus_state = e1mc_pkg::BUS_IDLE;
          next_data_oe = 1'b0;
        end
      end
      e1mc_pkg::BUS_WRITE: begin
        if (!(cs_act && wr_act)) begin
          next_bus_state = e1mc_pkg::BUS_IDLE;
        end
      end
    endcase
  end

  // Register bank and host port outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state <= e1mc_pkg::BUS_IDLE;
      reg_err <= e1mc_pkg::REG_RESET;
      reg_acc <= e1mc_pkg::REG_RESET;
      reg_ja <= e1mc_pkg::REG_RESET;
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
    end else if (clk_en) begin
      bus_state <= next_bus_state;
      reg_err <= next_reg_err;
      reg_acc <= next_reg_acc;
      reg_ja <= next_reg_ja;
      host_data_out <= next_data_out;
      host_data_oe <= next_data_oe;
    end
  end

  // ****************************************************************
  // Signalling debounce
  // ****************************************************************

  e1mc_sig_if #(.W(SIG_W)) sig_link ();

  // The filter period is a fixed DBNC_LIMIT clock count, with no multiframe alignment
  assign sig_link.enable = reg_err[e1mc_pkg::ERR_DBNC_BIT];
  assign sig_link.raw = sig_raw;
  assign sig_debounced = sig_link.filtered;

  e1mc_sig_debounce #(
    .W(SIG_W),
    .CNT_W(e1mc_pkg::DEBOUNCE_CNT_W),
    .LIMIT(DBNC_LIMIT)
  ) u_debounce (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .sig(sig_link.filt)
  );

  // ****************************************************************
  // Control outputs
  // ****************************************************************

  localparam int JA_DEPTH_W_L = e1mc_pkg::JA_DEPTH_W;

  logic next_loss_ind;
  logic [JA_DEPTH_W_L-1:0] depth_code;
  logic [7:0] next_depth;

  assign depth_code = reg_ja[e1mc_pkg::JA_DEPTH_LSB +: JA_DEPTH_W_L];

  // Loss indicator choice and FIFO depth in words
  always_comb begin
    if (reg_acc[e1mc_pkg::ACC_LOSSEL_BIT]) begin
      next_loss_ind = line_loss_state;
    end else begin
      next_loss_ind = line_loss_state | frame_align_lost;
    end
    next_depth = 8'(({5'h00, depth_code} + 8'h01) << e1mc_pkg::DEPTH_STEP_SHIFT);
  end

  // Output flops, insert strobes last exactly one cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bipolar_violation_insert <= 1'b0;
      crc_error_insert <= 1'b0;
      frame_align_error_insert <= 1'b0;
      nonframe_align_error_insert <= 1'b0;
      payload_error_insert <= 1'b0;
      forced_loss_of_signal <= 1'b0;
      signalling_debounce_select <= 1'b0;
      loss_indicator_output <= 1'b0;
      test_sequence_select <= 1'b0;
      prbs_reset <= 1'b0;
      frame_pulse_format_select <= 1'b0;
      jitter_atten_tx_active <= 1'b0;
      jitter_atten_rx_active <= 1'b0;
      jitter_fifo_centre <= 1'b0;
      jitter_fifo_depth <= 8'h00;
      jitter_atten_clear <= 1'b0;
    end else if (clk_en) begin
      bipolar_violation_insert <= err_rise[e1mc_pkg::ERR_BPV_BIT];
      crc_error_insert <= err_rise[e1mc_pkg::ERR_CRC_BIT];
      frame_align_error_insert <= err_rise[e1mc_pkg::ERR_FAS_BIT];
      nonframe_align_error_insert <= err_rise[e1mc_pkg::ERR_NFAS_BIT];
      payload_error_insert <= err_rise[e1mc_pkg::ERR_PAY_BIT];
      forced_loss_of_signal <= next_reg_err[e1mc_pkg::ERR_FLOS_BIT];
      signalling_debounce_select <= next_reg_err[e1mc_pkg::ERR_DBNC_BIT];
      loss_indicator_output <= next_loss_ind;
      test_sequence_select <= next_reg_acc[e1mc_pkg::ACC_SEQ_BIT];
      prbs_reset <= next_prbs_reset;
      frame_pulse_format_select <= next_reg_acc[e1mc_pkg::ACC_FP_BIT];
      jitter_atten_tx_active <= next_reg_ja[e1mc_pkg::JA_EN_BIT] &
                                next_reg_ja[e1mc_pkg::JA_DIR_BIT];
      jitter_atten_rx_active <= next_reg_ja[e1mc_pkg::JA_EN_BIT] &
                                ~next_reg_ja[e1mc_pkg::JA_DIR_BIT];
      jitter_fifo_centre <= next_centre;
      jitter_fifo_depth <= next_depth;
      jitter_atten_clear <= next_reg_ja[e1mc_pkg::JA_CLR_BIT];
    end
  end

endmodule

// [verification/e1mc_chk_assertions.sv]
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the maintenance control block
// ****************************************************************
module e1mc_chk #(
  parameter int SIG_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Watched ports
  input wire logic line_loss_state,
  input wire logic frame_align_lost,
  input wire logic loss_indicator_output,
  input wire logic bipolar_violation_insert,
  input wire logic crc_error_insert,
  input wire logic prbs_reset,
  input wire logic test_sequence_select,
  input wire logic jitter_atten_tx_active,
  input wire logic jitter_atten_rx_active,
  input wire logic jitter_fifo_centre,
  input wire logic [7:0] jitter_fifo_depth,
  input wire logic signalling_debounce_select,
  input wire logic [SIG_W-1:0] sig_raw,
  input wire logic [SIG_W-1:0] sig_debounced
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_LOSS_SET: assert property (clk_en && line_loss_state |=> loss_indicator_output)
    else $error("loss output missed");
  AST_LOSS_CLR: assert property (clk_en && !line_loss_state && !frame_align_lost
    |=> !loss_indicator_output) else $error("loss output without cause");
  AST_BPV_ONE: assert property (clk_en && bipolar_violation_insert
    |=> !bipolar_violation_insert) else $error("violation pulse too long");
  AST_CRC_ONE: assert property (clk_en && crc_error_insert |=> !crc_error_insert)
    else $error("crc pulse too long");
  AST_PRBS_SEL: assert property (prbs_reset |-> test_sequence_select)
    else $error("sequence reset without select");
  AST_CTR_ONE: assert property (clk_en && jitter_fifo_centre |=> !jitter_fifo_centre)
    else $error("centre pulse too long");
  AST_JA_PATH: assert property (!(jitter_atten_tx_active && jitter_atten_rx_active))
    else $error("attenuator on both paths");
  AST_DEPTH: assert property (jitter_fifo_depth != 8'h00 |->
    jitter_fifo_depth[3:0] == 4'h0 && jitter_fifo_depth <= 8'h80) else $error("bad depth");
  AST_DBNC_OFF: assert property (clk_en && !signalling_debounce_select
    |=> sig_debounced == $past(sig_raw)) else $error("undebounced path wrong");
  AST_DBNC_ON: assert property (signalling_debounce_select && $past(signalling_debounce_select)
    && $changed(sig_debounced) |-> sig_debounced == $past(sig_raw, 2)
    && sig_debounced == $past(sig_raw, 3)) else $error("debounce took unstable value");

  // Main scenarios reached
  COV_BPV: cover property (bipolar_violation_insert);
  COV_LOF: cover property (loss_indicator_output && !line_loss_state);
  COV_CTR: cover property (jitter_fifo_centre);
endmodule

bind e1mc_maint_ctrl e1mc_chk #(.SIG_W(SIG_W)) i_chk (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .line_loss_state(line_loss_state), .frame_align_lost(frame_align_lost),
  .loss_indicator_output(loss_indicator_output),
  .bipolar_violation_insert(bipolar_violation_insert), .crc_error_insert(crc_error_insert),
  .prbs_reset(prbs_reset), .test_sequence_select(test_sequence_select),
  .jitter_atten_tx_active(jitter_atten_tx_active),
  .jitter_atten_rx_active(jitter_atten_rx_active), .jitter_fifo_centre(jitter_fifo_centre),
  .jitter_fifo_depth(jitter_fifo_depth),
  .signalling_debounce_select(signalling_debounce_select),
  .sig_raw(sig_raw), .sig_debounced(sig_debounced)
);

// [verification/e1mc_host_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Host processor model on the register port
// ****************************************************************
module e1mc_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic host_cs_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic [4:0] host_addr,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe
);
  // Idle bus at time zero
  initial begin
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = 5'h00;
    host_data_in = 8'h00;
  end

  // Strobes held well past the synchroniser, then a long idle gap
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_data_in = d;
    host_cs_n = 1'b0;
    host_wr_n = 1'b0;
    repeat (8) @(negedge clk);
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    host_data_in = ~d; // Released data stops showing the last value
    repeat (8) @(negedge clk);
  endtask

  // Read sampled late in the strobe, when output has settled
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk);
    host_addr = a;
    host_cs_n = 1'b0;
    host_rd_n = 1'b0;
    repeat (8) @(negedge clk);
    d = host_data_out;
    oe = host_data_oe;
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // One more single error: bit cleared before it is set again
  task automatic ins(input logic [4:0] a, input logic [7:0] d);
    wr(a, 8'h00);
    wr(a, d);
  endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
// ****************************************************************
// Testbench for the maintenance control block
// ****************************************************************
module tb_top;
  logic clk, sys_rst, clk_en, line_loss_state, frame_align_lost;
  logic [3:0] sig_raw;
  wire logic host_cs_n, host_rd_n, host_wr_n, host_data_oe;
  wire logic [4:0] host_addr;
  wire logic [7:0] host_data_in, host_data_out, jitter_fifo_depth;
  wire logic [3:0] sig_debounced;
  wire logic bpv, crc, fas, nfas, pay, flos, dsel, loss, tseq, prst, fps, jtx, jrx, jctr, jclr;
  logic [6:0] pl;
  int pc [7];
  int num_errors = 0;
  int check_count = 0;

  e1mc_host_model i_host (.clk(clk), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe));

  e1mc_maint_ctrl #(.DEBOUNCE_CYCLES(20)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
    .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .line_loss_state(line_loss_state),
    .frame_align_lost(frame_align_lost), .sig_raw(sig_raw),
    .bipolar_violation_insert(bpv), .crc_error_insert(crc), .frame_align_error_insert(fas),
    .nonframe_align_error_insert(nfas), .payload_error_insert(pay),
    .forced_loss_of_signal(flos), .signalling_debounce_select(dsel),
    .sig_debounced(sig_debounced), .loss_indicator_output(loss),
    .test_sequence_select(tseq), .prbs_reset(prst), .frame_pulse_format_select(fps),
    .jitter_atten_tx_active(jtx), .jitter_atten_rx_active(jrx), .jitter_fifo_centre(jctr),
    .jitter_fifo_depth(jitter_fifo_depth), .jitter_atten_clear(jclr));

  // Count every one-shot output
  assign pl = {bpv, crc, fas, nfas, pay, prst, jctr};
  always @(negedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (pl[i] === 1'b1) begin
        pc[6 - i]++;
      end
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [4:0] ra [4] = '{5'h10, 5'h13, 5'h18, 5'h11};
    logic [7:0] d;
    logic oe;
    chk(jitter_fifo_depth, 8'h10);
    i_host.wr(5'h11, 8'hFF); // Unmapped write must change nothing
    foreach (ra[i]) begin
      i_host.rd(ra[i], d, oe);
      chk(d, 8'h00);
      chk({7'h00, oe}, 8'h01);
      chk({7'h00, host_data_oe}, 8'h00);
    end
  endtask

  task automatic t_errins();
    int b [5] = '{7, 6, 5, 4, 2};
    int p0;
    foreach (b[i]) begin
      p0 = pc[i];
      i_host.ins(5'h10, 8'h01 << b[i]);
      chk(8'(pc[i] - p0), 8'h01);
      i_host.wr(5'h10, 8'h01 << b[i]);
      i_host.wr(5'h10, 8'h00);
      chk(8'(pc[i] - p0), 8'h01);
    end
  endtask

  task automatic t_flos();
    logic [7:0] d;
    logic oe;
    i_host.wr(5'h10, 8'hFF);
    chk({6'h00, flos, dsel}, 8'h03);
    i_host.rd(5'h10, d, oe);
    chk(d, 8'hFD);
    i_host.wr(5'h10, 8'h00);
    chk({6'h00, flos, dsel}, 8'h00);
  endtask

  task automatic t_dbnc();
    sig_raw = 4'h5;
    cyc(3);
    chk({4'h0, sig_debounced}, 8'h05);
    i_host.wr(5'h10, 8'h01);
    sig_raw = 4'hA;
    cyc(10);
    chk({4'h0, sig_debounced}, 8'h05);
    cyc(15);
    chk({4'h0, sig_debounced}, 8'h0A);
    i_host.wr(5'h10, 8'h00);
    // Clock enable low freezes the direct path
    clk_en = 1'b0;
    sig_raw = 4'h3;
    cyc(3);
    chk({4'h0, sig_debounced}, 8'h0A);
    clk_en = 1'b1;
    cyc(2);
    chk({4'h0, sig_debounced}, 8'h03);
  endtask

  task automatic t_loss();
    i_host.wr(5'h13, 8'h04);
    frame_align_lost = 1'b1;
    cyc(2);
    chk({7'h00, loss}, 8'h00);
    line_loss_state = 1'b1;
    cyc(2);
    chk({7'h00, loss}, 8'h01);
    line_loss_state = 1'b0;
    i_host.wr(5'h13, 8'h00);
    chk({7'h00, loss}, 8'h01);
    frame_align_lost = 1'b0;
    cyc(2);
    chk({7'h00, loss}, 8'h00);
  endtask

  task automatic t_access();
    logic [7:0] d;
    logic oe;
    int p0 = pc[5];
    i_host.wr(5'h13, 8'hFF);
    chk({6'h00, tseq, fps}, 8'h03);
    i_host.wr(5'h13, 8'hFF);
    chk(8'(pc[5] - p0), 8'h02);
    i_host.rd(5'h13, d, oe);
    chk(d, 8'h07);
    i_host.wr(5'h13, 8'h00);
    chk({6'h00, tseq, fps}, 8'h00);
    chk(8'(pc[5] - p0), 8'h02);
  endtask

  task automatic t_jitter();
    logic [7:0] d;
    logic oe;
    int p0;
    for (int c = 0; c < 8; c++) begin
      i_host.wr(5'h18, 8'(c << 2));
      chk(jitter_fifo_depth, 8'((c + 1) * 16));
    end
    i_host.wr(5'h18, 8'h80);
    chk({6'h00, jtx, jrx}, 8'h01);
    i_host.wr(5'h18, 8'hC0);
    chk({6'h00, jtx, jrx}, 8'h02);
    i_host.wr(5'h18, 8'h40);
    chk({6'h00, jtx, jrx}, 8'h00);
    p0 = pc[6];
    i_host.wr(5'h18, 8'h60);
    i_host.wr(5'h18, 8'h60);
    i_host.wr(5'h18, 8'h40);
    chk(8'(pc[6] - p0), 8'h02);
    i_host.wr(5'h18, 8'hFF);
    chk({7'h00, jclr}, 8'h01);
    i_host.rd(5'h18, d, oe);
    chk(d, 8'hFE);
  endtask

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog against a hung run, about five times the expected length
  initial begin
    #40000;
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    line_loss_state = 1'b0;
    frame_align_lost = 1'b0;
    sig_raw = 4'h0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    cyc(2);
    t_reset();
    t_errins();
    t_flos();
    t_dbnc();
    t_loss();
    t_access();
    t_jitter();
    end_sim();
  end
endmodule
